// *** core/afecfg_regs.sv ***
// How it works
// RULE1 - setup_one bit 0 clear powers the device down, set makes it active, reset value set.
// RULE2 - setup_one bit 1 picks single-ended (0) or double sampling (1), default double sampling.
// RULE3 - setup_one bit 2 routes the first video pin (0) or the second (1), default first.
// RULE4 - setup_one bit 3 set shorts the two video pins together, default open.
// RULE5 - setup_one bits 5:4 give zero output for 00/01, positive full scale for 10, negative for 11.
// RULE6 - the host sets setup_one bit 6 only for the 2:1 ratio with internal clamping on.
// RULE7 - with the fast flag set the host should program the reset timing adjust to 01.
// RULE8 - setup_two bit 2 set inverts output data polarity, default follow input.
// RULE9 - setup_two bit 3 set powers down the clamp reference converter and floats its output.
// RULE10 - setup_two bit 5 picks clamp reference range, 0 up to supply, 1 up to top reference.
// RULE11 - setup_two bits 7:6 set output latency in converter clock periods, default 00.
// RULE12 - a converter clock period is two master clocks, three in operating mode 2.
// RULE13 - latency 00 is minimum, 10 adds two converter periods, other codes add delay.
// RULE14 - setup_four bit 3 clear disables reset level clamping, set enables it.
// RULE15 - the host writes zero to setup_one bit 7 and setup_two bit 4, ones to setup_two 1:0.
// RULE16 - reset loads all three setup registers with their defaults before any write is taken.
`timescale 1ns/10ps
module afecfg_regs
  import afecfg_pkg::*;
#(
  parameter int LAT_W = 4
)
(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         wr_en,
  input  wire afecfg_wr_t   wr,
  input  wire logic [5:0]   rd_addr,
  input  wire logic         mode2_sel,
  output logic [7:0]        rd_data,
  output afecfg_ctrl_t      ctrl,
  output logic [1:0]        conv_period_mclk,
  output logic [LAT_W-1:0]  latency_conv_periods,
  output logic [LAT_W-1:0]  latency_mclk
);

  logic [7:0]       setup_one_q;
  logic [7:0]       setup_one_d;
  logic [7:0]       setup_two_q;
  logic [7:0]       setup_two_d;
  logic [7:0]       setup_four_q;
  logic [7:0]       setup_four_d;
  logic [7:0]       rd_data_d;
  logic             soft_reset;
  logic             restore_defaults;
  logic             wr_setup_one;
  logic             wr_setup_two;
  logic             wr_setup_four;
  logic             rd_setup_one;
  logic             rd_setup_two;
  logic             rd_setup_four;

  // the longest latency, three periods of three master clocks, needs four bits
  if (LAT_W < 4) begin : g_lat_w_check
    $error("latency outputs need at least four bits");
  end

  // one address compare shared by the write and the read decode
  function automatic logic addr_match(input logic [5:0] addr, input logic [5:0] target);
    addr_match = (addr == target);
  endfunction

  // latency code to extra converter periods; 01 is one, 11 three
  function automatic logic [1:0] latency_decode(input logic [1:0] code);
    case (code)
      2'b00:   latency_decode = 2'd0;
      2'b01:   latency_decode = 2'd1;
      2'b10:   latency_decode = 2'd2;
      2'b11:   latency_decode = 2'd3;
      default: latency_decode = 2'd0;
    endcase
  endfunction

  // any write to the software reset address restores every default
  assign soft_reset       = wr_en && addr_match(wr.addr, ADDR_SOFT_RESET);
  assign restore_defaults = reset || soft_reset; // RULE16

  // one write strobe per stored register; unmapped addresses fall through
  assign wr_setup_one  = wr_en && addr_match(wr.addr, ADDR_SETUP_ONE);
  assign wr_setup_two  = wr_en && addr_match(wr.addr, ADDR_SETUP_TWO);
  assign wr_setup_four = wr_en && addr_match(wr.addr, ADDR_SETUP_FOUR);

  assign setup_one_d  = wr_setup_one ? wr.data : setup_one_q;
  assign setup_two_d  = wr_setup_two ? wr.data : setup_two_q;
  assign setup_four_d = wr_setup_four ? wr.data : setup_four_q;

  // a block per register keeps each reset branch to constants only
  always_ff @(posedge sys_clk) begin
    if (restore_defaults) begin
      setup_one_q <= SETUP_ONE_RESET; // RULE16
    end else begin
      setup_one_q <= setup_one_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (restore_defaults) begin
      setup_two_q <= SETUP_TWO_RESET; // RULE16
    end else begin
      setup_two_q <= setup_two_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (restore_defaults) begin
      setup_four_q <= SETUP_FOUR_RESET; // RULE16
    end else begin
      setup_four_q <= setup_four_d;
    end
  end

  // reserved bits are stored as written; the host keeps them at their fixed values
  assign rd_setup_one  = addr_match(rd_addr, ADDR_SETUP_ONE);
  assign rd_setup_two  = addr_match(rd_addr, ADDR_SETUP_TWO);
  assign rd_setup_four = addr_match(rd_addr, ADDR_SETUP_FOUR);
  assign rd_data_d = rd_setup_one  ? setup_one_q :
                     rd_setup_two  ? setup_two_q :
                     rd_setup_four ? setup_four_q : 8'h00; // RULE15

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_data_d;
    end
  end

  // one named wire per control so each decode traces back to its bit
  logic             power_on_w;
  logic             double_sample_w;
  logic             input_first_w;
  logic             input_second_w;
  logic             input_short_w;
  logic             fast_ratio_w;
  logic             output_invert_w;
  logic             clamp_external_w;
  logic             clamp_conv_on_w;
  logic             clamp_range_w;
  logic             clamp_enable_w;
  logic [1:0]       ofs_code;
  afecfg_zero_out_t zero_out;

  assign power_on_w       = setup_one_q[POWER_ENABLE_BIT];  // RULE1
  assign double_sample_w  = setup_one_q[DOUBLE_SAMPLE_BIT]; // RULE2
  assign input_second_w   = setup_one_q[INPUT_SELECT_BIT];  // RULE3
  assign input_first_w    = !input_second_w;                // RULE3
  assign input_short_w    = setup_one_q[INPUT_SHORT_BIT];   // RULE4
  // the flag only steers analogue timing; the host owns its correct use
  assign fast_ratio_w     = setup_one_q[FAST_RATIO_BIT];    // RULE6
  assign output_invert_w  = setup_two_q[OUTPUT_INVERT_BIT]; // RULE8
  assign clamp_external_w = setup_two_q[CLAMP_EXT_BIT];     // RULE9
  assign clamp_conv_on_w  = !clamp_external_w;              // RULE9
  assign clamp_range_w    = setup_two_q[CLAMP_RANGE_BIT];   // RULE10
  assign clamp_enable_w   = setup_four_q[CLAMP_ENABLE_BIT]; // RULE14
  assign ofs_code         = setup_one_q[ZERO_OFFSET_LSB +: 2];
  // codes 00 and 01 both give zero output, so they share one state
  assign zero_out = (ofs_code == AFECFG_OFS_POS) ? AFECFG_OUT_POS :
                    (ofs_code == AFECFG_OFS_NEG) ? AFECFG_OUT_NEG : AFECFG_OUT_ZERO; // RULE5

  afecfg_ctrl_t ctrl_d;
  always_comb begin
    ctrl_d.power_on               = power_on_w;       // RULE1
    ctrl_d.double_sample_mode     = double_sample_w;  // RULE2
    ctrl_d.video_in_first_sel     = input_first_w;    // RULE3
    ctrl_d.video_in_second_sel    = input_second_w;   // RULE3
    ctrl_d.video_input_short      = input_short_w;    // RULE4
    ctrl_d.gain_stage_zero_offset = zero_out;         // RULE5
    ctrl_d.fast_ratio_flag        = fast_ratio_w;     // RULE6
    ctrl_d.output_invert          = output_invert_w;  // RULE8
    ctrl_d.clamp_ref_converter_on = clamp_conv_on_w;  // RULE9
    ctrl_d.clamp_ref_external     = clamp_external_w; // RULE9
    ctrl_d.clamp_ref_range        = clamp_range_w;    // RULE10
    ctrl_d.internal_clamp_on      = clamp_enable_w;   // RULE14
  end

  logic [1:0]       conv_period_d;
  logic [1:0]       lat_conv_d;
  logic [LAT_W-1:0] lat_conv_ext;
  logic [LAT_W-1:0] period_ext;
  logic [LAT_W-1:0] lat_mclk_d;
  assign conv_period_d = mode2_sel ? CONV_PERIOD_MODE2 : CONV_PERIOD_NORMAL; // RULE12
  assign lat_conv_d    = latency_decode(setup_two_q[LATENCY_LSB +: 2]); // RULE11 RULE13
  // both factors are widened first so three times three keeps its top bit
  assign lat_conv_ext  = {{(LAT_W-2){1'b0}}, lat_conv_d};
  assign period_ext    = {{(LAT_W-2){1'b0}}, conv_period_d};
  assign lat_mclk_d    = lat_conv_ext * period_ext; // RULE12

  // registered so the analogue controls never see decode glitches
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl <= '0;
    end else begin
      ctrl <= ctrl_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      conv_period_mclk <= CONV_PERIOD_NORMAL;
    end else begin
      conv_period_mclk <= conv_period_d; // RULE12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      latency_conv_periods <= '0;
    end else begin
      latency_conv_periods <= lat_conv_ext; // RULE11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      latency_mclk <= '0;
    end else begin
      latency_mclk <= lat_mclk_d; // RULE12
    end
  end

endmodule

// *** inc/afecfg_pkg.sv ***
package afecfg_pkg;
  // register addresses on the serial control interface
  localparam logic [5:0] ADDR_SETUP_ONE  = 6'h01;
  localparam logic [5:0] ADDR_SETUP_TWO  = 6'h02;
  localparam logic [5:0] ADDR_SOFT_RESET = 6'h04;
  localparam logic [5:0] ADDR_SETUP_FOUR = 6'h06;

  localparam logic [7:0] SETUP_ONE_RESET  = 8'h03;
  localparam logic [7:0] SETUP_TWO_RESET  = 8'h23;
  localparam logic [7:0] SETUP_FOUR_RESET = 8'h05;

  // setup_one fields
  localparam int POWER_ENABLE_BIT   = 0;
  localparam int DOUBLE_SAMPLE_BIT  = 1;
  localparam int INPUT_SELECT_BIT   = 2;
  localparam int INPUT_SHORT_BIT    = 3;
  localparam int ZERO_OFFSET_LSB    = 4;
  localparam int FAST_RATIO_BIT     = 6;
  // setup_two fields
  localparam int OUTPUT_INVERT_BIT  = 2;
  localparam int CLAMP_EXT_BIT      = 3;
  localparam int CLAMP_RANGE_BIT    = 5;
  localparam int LATENCY_LSB        = 6;
  // setup_four field
  localparam int CLAMP_ENABLE_BIT   = 3;

  // master clock periods per converter clock period
  localparam logic [1:0] CONV_PERIOD_NORMAL = 2'd2;
  localparam logic [1:0] CONV_PERIOD_MODE2  = 2'd3;

  typedef enum logic [1:0] {
    AFECFG_OFS_ZERO  = 2'b00,
    AFECFG_OFS_ZERO1 = 2'b01,
    AFECFG_OFS_POS   = 2'b10,
    AFECFG_OFS_NEG   = 2'b11
  } afecfg_offset_t;

  typedef enum logic [1:0] {
    AFECFG_OUT_ZERO = 2'b00,
    AFECFG_OUT_POS  = 2'b01,
    AFECFG_OUT_NEG  = 2'b10
  } afecfg_zero_out_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
  } afecfg_wr_t;

  typedef struct packed {
    logic             power_on;
    logic             double_sample_mode;
    logic             video_in_first_sel;
    logic             video_in_second_sel;
    logic             video_input_short;
    afecfg_zero_out_t gain_stage_zero_offset;
    logic             fast_ratio_flag;
    logic             output_invert;
    logic             clamp_ref_converter_on;
    logic             clamp_ref_external;
    logic             clamp_ref_range;
    logic             internal_clamp_on;
  } afecfg_ctrl_t;
endpackage

// *** verif/afecfg_host.sv ***
`timescale 1ns/10ps
module afecfg_host
  import afecfg_pkg::*;
(
  input  wire logic       sys_clk,
  output logic            wr_en,
  output afecfg_wr_t      wr,
  output logic [5:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  initial begin
    wr_en = 1'b0;
    wr = '0;
    rd_addr = 6'h00;
  end
  task put(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ADDR_SETUP_ONE) v[7] = 1'b0;
    if (a == ADDR_SETUP_TWO) v = (v & 8'hef) | 8'h03;
    @(posedge sys_clk);
    wr_en <= 1'b1;
    wr <= '{addr: a, data: v};
    @(posedge sys_clk);
    wr_en <= 1'b0;
    // idle bus carries junk so a stale match cannot pass
    wr <= ~wr;
  endtask
  task get(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd_addr <= a;
    @(posedge sys_clk);
    #1 d = rd_data;
  endtask
endmodule

// *** verif/afecfg_regs_asserts.sv ***
`timescale 1ns/10ps
module afecfg_regs_asserts
  import afecfg_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         reset,
  input wire logic         wr_en,
  input wire afecfg_wr_t   wr,
  input wire logic         mode2_sel,
  input wire afecfg_ctrl_t ctrl,
  input wire logic [1:0]   conv_period_mclk,
  input wire logic [3:0]   latency_conv_periods
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s1; wr_en && wr.addr == ADDR_SETUP_ONE ##1 !wr_en; endsequence
  sequence s2; wr_en && wr.addr == ADDR_SETUP_TWO ##1 !wr_en; endsequence
  property p_pwr; s1 |=> ctrl.power_on == $past(wr.data[0], 2)
    && ctrl.double_sample_mode == $past(wr.data[1], 2); endproperty
  a_pwr: assert property (p_pwr) else $error("power or sampling mode wrong");
  property p_sel; s1 |=> ctrl.video_in_second_sel == $past(wr.data[2], 2)
    && ctrl.video_in_first_sel != ctrl.video_in_second_sel
    && ctrl.video_input_short == $past(wr.data[3], 2); endproperty
  a_sel: assert property (p_sel) else $error("input pin routing wrong");
  property p_ofs; s1 |=> ctrl.gain_stage_zero_offset == ($past(wr.data[5], 2) ?
    ($past(wr.data[4], 2) ? AFECFG_OUT_NEG : AFECFG_OUT_POS) : AFECFG_OUT_ZERO); endproperty
  a_ofs: assert property (p_ofs) else $error("zero offset decode wrong");
  property p_inv; s2 |=> ctrl.output_invert == $past(wr.data[2], 2)
    && ctrl.clamp_ref_external == $past(wr.data[3], 2)
    && ctrl.clamp_ref_converter_on != ctrl.clamp_ref_external; endproperty
  a_inv: assert property (p_inv) else $error("invert or clamp reference wrong");
  property p_rng; s2 |=> ctrl.clamp_ref_range == $past(wr.data[5], 2)
    && latency_conv_periods == {2'h0, $past(wr.data[7:6], 2)}; endproperty
  a_rng: assert property (p_rng) else $error("range or latency wrong");
  property p_per; $stable(mode2_sel) && !$past(reset) |->
    conv_period_mclk == (mode2_sel ? CONV_PERIOD_MODE2 : CONV_PERIOD_NORMAL); endproperty
  a_per: assert property (p_per) else $error("converter period wrong");
  property p_clamp; wr_en && wr.addr == ADDR_SETUP_FOUR ##1 !wr_en |=>
    ctrl.internal_clamp_on == $past(wr.data[3], 2); endproperty
  a_clamp: assert property (p_clamp) else $error("clamp enable wrong");
  property p_dflt; $past(reset, 2) && !$past(reset) && !$past(wr_en) |-> ctrl.power_on
    && ctrl.double_sample_mode && ctrl.clamp_ref_range && !ctrl.output_invert; endproperty
  a_dflt: assert property (p_dflt) else $error("defaults after reset wrong");
endmodule
bind afecfg_regs afecfg_regs_asserts u_chk (.sys_clk(sys_clk), .reset(reset), .wr_en(wr_en),
  .wr(wr), .mode2_sel(mode2_sel), .ctrl(ctrl), .conv_period_mclk(conv_period_mclk),
  .latency_conv_periods(latency_conv_periods));

// *** verif/afecfg_regs_test.sv ***
`timescale 1ns/10ps
module afecfg_regs_test;
  import afecfg_pkg::*;
  logic         sys_clk, reset, mode2_sel, wr_en;
  afecfg_wr_t   wr;
  logic [5:0]   rd_addr;
  logic [7:0]   rd_data;
  afecfg_ctrl_t ctrl;
  logic [1:0]   per;
  logic [3:0]   lat_c, lat_m;
  int           num_errors, n_tests, cyc;
  afecfg_regs DUT (.sys_clk(sys_clk), .reset(reset), .wr_en(wr_en), .wr(wr),
    .rd_addr(rd_addr), .mode2_sel(mode2_sel), .rd_data(rd_data), .ctrl(ctrl),
    .conv_period_mclk(per), .latency_conv_periods(lat_c), .latency_mclk(lat_m));
  afecfg_host host (.sys_clk(sys_clk), .wr_en(wr_en), .wr(wr), .rd_addr(rd_addr),
    .rd_data(rd_data));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_dflt;
    logic [7:0] d;
    host.get(ADDR_SETUP_ONE, d);
    chk(d, SETUP_ONE_RESET);
    host.get(ADDR_SETUP_TWO, d);
    chk(d, SETUP_TWO_RESET);
    host.get(6'h3f, d);
    chk(d, 8'h00);
    chk({ctrl.power_on, ctrl.double_sample_mode, ctrl.video_in_first_sel}, 8'h07);
    chk({ctrl.video_input_short, ctrl.output_invert, lat_c}, 8'h00);
    $display("defaults done");
  endtask
  task t_one;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      host.put(ADDR_SETUP_ONE, {2'b00, i[1:0], 4'h5});
      host.get(ADDR_SETUP_ONE, d);
      chk(ctrl.gain_stage_zero_offset, i == 2 ? AFECFG_OUT_POS : i == 3 ? AFECFG_OUT_NEG
        : AFECFG_OUT_ZERO);
      chk({ctrl.power_on, ctrl.double_sample_mode, ctrl.video_in_second_sel,
        ctrl.video_input_short}, 8'h0a);
    end
    // fast flag only with clamping on; the timing adjust register lies outside this block
    host.put(ADDR_SETUP_FOUR, 8'h0d);
    host.put(6'h03, 8'h1f);
    host.put(ADDR_SETUP_ONE, 8'hca);
    host.get(ADDR_SETUP_ONE, d);
    chk(d, 8'h4a);
    chk({ctrl.fast_ratio_flag, ctrl.power_on, ctrl.double_sample_mode,
      ctrl.video_in_first_sel, ctrl.video_input_short}, 8'h17);
    $display("setup one done");
  endtask
  task t_two;
    logic [7:0] d, e;
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      mode2_sel <= m[0];
      for (int l = 0; l < 4; l++) begin
        e = {l[1:0], ~m[0], 1'b1, m[0], m[0], 2'b00};
        host.put(ADDR_SETUP_TWO, e);
        host.get(ADDR_SETUP_TWO, d);
        chk(d, (e & 8'hef) | 8'h03);
        chk(lat_c, 8'(l));
        chk(lat_m, 8'(l * (2 + m)));
        chk({ctrl.output_invert, ctrl.clamp_ref_external, ctrl.clamp_ref_converter_on,
          ctrl.clamp_ref_range}, {4'h0, m[0], m[0], ~m[0], ~m[0]});
      end
    end
    $display("setup two done");
  endtask
  task t_four;
    logic [7:0] d;
    host.put(ADDR_SETUP_FOUR, 8'h0d);
    host.get(ADDR_SETUP_FOUR, d);
    chk(ctrl.internal_clamp_on, 8'h01);
    host.put(ADDR_SOFT_RESET, 8'h00);
    host.put(6'h3f, 8'hff);
    host.get(ADDR_SETUP_ONE, d);
    chk(d, SETUP_ONE_RESET);
    host.get(ADDR_SETUP_FOUR, d);
    chk(d, SETUP_FOUR_RESET);
    chk(ctrl.internal_clamp_on, 8'h00);
    $display("soft reset done");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    reset = 1'b1;
    mode2_sel = 1'b0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    t_dflt();
    t_one();
    t_two();
    t_four();
    end_of_test();
  end
endmodule
